// ### hw/clg_config.sv
// What this block does
// - power-down enables act only while pin asserted
// - pll a, b, c off bits 21, 45, 69
// - post divider off bits 120 to 123
// - reference dividers a, b, c set0 fields
// - c set1 reference divider when select high
// - feedback divider: a-counter low, m-counter high
// - post a, b, c codes; c by select
// - post d code chosen by select pin
// - post code decodes to sixteen divide ratios
// - loop filter bit picks short or long constant
// - charge pump bit picks low or high current
// - whole image clears to zero at reset
// - each byte reaches the controls one edge after it is written
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ps
module clg_config
    import clg_pkg::*;
(
    input  wire logic              clk,                    // 125 MHz system clock
    input  wire logic              sys_rst,                // synchronous reset, active high
    input  clg_bus_t               reg_req,                // register write/read request
    output logic      [DATA_W-1:0] reg_rdata,              // read data, cycle after read strobe
    input  wire logic              powerdown_request_pin,  // asynchronous power-down request
    input  wire logic              cd_set_select_pin,      // asynchronous c/d set select
    output clg_pll_t               pll_a,                  // pll a controls
    output clg_pll_t               pll_b,                  // pll b controls
    output clg_pll_t               pll_c,                  // pll c controls, active set
    output clg_post_t              post_a,                 // post divider a controls
    output clg_post_t              post_b,                 // post divider b controls
    output clg_post_t              post_c,                 // post divider c controls
    output clg_post_t              post_d,                 // post divider d controls
    output logic                   pd_active,              // synchronised power-down level
    output logic                   cd_set1_active          // synchronised set select level
);

    logic                pd_meta_r;
    logic                pd_sync_r;
    logic                sel_meta_r;
    logic                sel_sync_r;
    logic [DATA_W-1:0]   wr_byte;
    logic [IMG_BITS-1:0] image_w;
    logic [CODE_W-1:0]   code_c;
    logic [CODE_W-1:0]   code_d;

    // reserved bits are stored as zero whatever the host sends
    function automatic logic [DATA_W-1:0] rsvd_clean(input logic [ADDR_W-1:0] a,
                                                     input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] r;
        r = d;
        if (a == RSVD_BYTE_LF) begin
            r = d & RSVD_MASK_LF;
        end else if (a == RSVD_BYTE_PD) begin
            r = d & RSVD_MASK_PD;
        end
        return r;
    endfunction

    // assemble one pll's controls from its field positions
    function automatic clg_pll_t pll_pick(input logic [IMG_BITS-1:0] img,
                                          input int                  ref_lsb,
                                          input int                  fb_lsb,
                                          input int                  cp_bit,
                                          input int                  lf_bit,
                                          input int                  pd_bit,
                                          input logic                pd_on);
        clg_pll_t p;
        p.off       = img[pd_bit] & pd_on;
        p.loop_long = img[lf_bit];
        p.pump_high = img[cp_bit];
        p.ref_div   = img[ref_lsb +: REF_W];
        p.fb_a      = img[fb_lsb +: FB_A_W];
        p.fb_m      = img[fb_lsb + FB_A_W +: FB_M_W];
        return p;
    endfunction

    // pin synchronisers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pd_meta_r <= 1'b0;
            pd_sync_r <= 1'b0;
        end else begin
            pd_meta_r <= powerdown_request_pin;
            pd_sync_r <= pd_meta_r;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sel_meta_r <= 1'b0;
            sel_sync_r <= 1'b0;
        end else begin
            sel_meta_r <= cd_set_select_pin;
            sel_sync_r <= sel_meta_r;
        end
    end

    assign pd_active      = pd_sync_r;
    assign cd_set1_active = sel_sync_r;

    assign wr_byte = rsvd_clean(reg_req.addr, reg_req.wdata);

    // a written byte lands in the image at the write edge
    clg_image_mem #(
        .BYTES   (IMG_BYTES)
    ) u_image (
        .clk     (clk),
        .sys_rst (sys_rst),
        .wr_en   (reg_req.wr),
        .wr_addr (reg_req.addr),
        .wr_data (wr_byte),
        .rd_en   (reg_req.rd),
        .rd_addr (reg_req.addr),
        .rd_data (reg_rdata),
        .image   (image_w)
    );

    // pll a and b controls
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pll_a <= '0;
            pll_b <= '0;
        end else begin
            pll_a <= pll_pick(image_w, REF_A_LSB, FB_A_LSB, CP_A_BIT, LF_A_BIT, PD_A_BIT, pd_sync_r);
            pll_b <= pll_pick(image_w, REF_B_LSB, FB_B_LSB, CP_B_BIT, LF_B_BIT, PD_B_BIT, pd_sync_r);
        end
    end

    // pll c takes the set chosen by the select pin; its off bit is shared by both sets
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pll_c <= '0;
        end else if (sel_sync_r) begin
            pll_c <= pll_pick(image_w, REF_C1_LSB, FB_C1_LSB, PUMP_HIGH_CURRENT_C_SET0_BIT, LF_C1_BIT, PD_C_BIT, pd_sync_r);
        end else begin
            pll_c <= pll_pick(image_w, REF_C0_LSB, FB_C0_LSB, CP_C0_BIT, LF_C0_BIT, PD_C_BIT, pd_sync_r);
        end
    end

    assign code_c = sel_sync_r ? image_w[OUT_DIVIDER_CODE_C_SET0_LSB +: CODE_W] : image_w[POST_C0_LSB +: CODE_W];
    assign code_d = sel_sync_r ? image_w[OUT_DIVIDER_CODE_D_SET0_LSB +: CODE_W] : image_w[POST_D0_LSB +: CODE_W];

    clg_postdiv u_post_a (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .code       (image_w[POST_A_LSB +: CODE_W]),
        .off_enable (image_w[PDPOST_LSB]),
        .pd_active  (pd_sync_r),
        .post       (post_a)
    );

    clg_postdiv u_post_b (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .code       (image_w[POST_B_LSB +: CODE_W]),
        .off_enable (image_w[PDPOST_LSB + 1]),
        .pd_active  (pd_sync_r),
        .post       (post_b)
    );

    clg_postdiv u_post_c (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .code       (code_c),
        .off_enable (image_w[PDPOST_LSB + 2]),
        .pd_active  (pd_sync_r),
        .post       (post_c)
    );

    clg_postdiv u_post_d (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .code       (code_d),
        .off_enable (image_w[PDPOST_LSB + 3]),
        .pd_active  (pd_sync_r),
        .post       (post_d)
    );

    // checks beside the logic they guard

    a_pd_gate_pll: assert property (@(posedge clk) disable iff (sys_rst)
        !pd_sync_r |=> !pll_a.off && !pll_b.off && !pll_c.off)
        else $error("pll switched off without power-down request");

    a_pll_off_bits: assert property (@(posedge clk) disable iff (sys_rst)
        pd_sync_r && image_w[PD_B_BIT] ##1 pd_sync_r |-> pll_b.off && (pll_c.off == $past(image_w[PD_C_BIT])))
        else $error("pll off does not follow its enable bit");

    a_post_off_bits: assert property (@(posedge clk) disable iff (sys_rst)
        pd_sync_r |=> post_d.off == $past(image_w[PDPOST_LSB + 3]) && post_a.off == $past(image_w[PDPOST_LSB]))
        else $error("post divider off does not follow its enable bit");

    a_ref_a_write: assert property (@(posedge clk) disable iff (sys_rst)
        reg_req.wr && reg_req.addr == 4'h0 ##1 !(reg_req.wr && reg_req.addr == 4'h0)
            |=> pll_a.ref_div == $past(reg_req.wdata, 2))
        else $error("written reference divider a not applied two cycles later");

    a_ref_c_select: assert property (@(posedge clk) disable iff (sys_rst)
        sel_sync_r |=> pll_c.ref_div == $past(image_w[REF_C1_LSB +: REF_W]))
        else $error("pll c reference divider not from second set");

    a_ref_c_set0: assert property (@(posedge clk) disable iff (sys_rst)
        !sel_sync_r |=> pll_c.ref_div == $past(image_w[REF_C0_LSB +: REF_W])
            && pll_b.ref_div == $past(image_w[REF_B_LSB +: REF_W]))
        else $error("reference divider taken from wrong field");

    a_fb_split: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> pll_b.fb_a == $past(image_w[FB_B_LSB +: FB_A_W])
            && pll_b.fb_m == $past(image_w[FB_B_LSB + FB_A_W +: FB_M_W]))
        else $error("feedback divider split into wrong counters");

    a_post_c_select: assert property (@(posedge clk) disable iff (sys_rst)
        sel_sync_r |=> post_c.code == $past(image_w[OUT_DIVIDER_CODE_C_SET0_LSB +: CODE_W])
            && post_b.code == $past(image_w[POST_B_LSB +: CODE_W]))
        else $error("post divider c code not from second set");

    a_post_d_select: assert property (@(posedge clk) disable iff (sys_rst)
        !sel_sync_r |=> post_d.code == $past(image_w[POST_D0_LSB +: CODE_W]))
        else $error("post divider d code not from first set");

    a_ratio_top: assert property (@(posedge clk) disable iff (sys_rst)
        post_a.code == 4'hf |-> post_a.ratio == 6'h32)
        else $error("top code does not divide by fifty");

    a_loop_filter_c: assert property (@(posedge clk) disable iff (sys_rst)
        sel_sync_r |=> pll_c.loop_long == $past(image_w[LF_C1_BIT]))
        else $error("loop filter of second c set not applied");

    a_pump_c: assert property (@(posedge clk) disable iff (sys_rst)
        !sel_sync_r |=> pll_c.pump_high == $past(image_w[CP_C0_BIT]))
        else $error("charge pump of first c set not applied");

    a_reset_clear: assert property (@(posedge clk)
        sys_rst |=> image_w == IMG_RESET && pll_a == '0 && post_d == '0)
        else $error("image not cleared by reset");

    a_sel_follow: assert property (@(posedge clk) disable iff (sys_rst)
        cd_set_select_pin [*2] |=> sel_sync_r)
        else $error("set select pin not followed within two cycles");

    a_read_back: assert property (@(posedge clk) disable iff (sys_rst)
        reg_req.rd |=> reg_rdata == $past(image_w[reg_req.addr * DATA_W +: DATA_W]))
        else $error("read data does not match stored byte");

    a_pd_follow: assert property (@(posedge clk) disable iff (sys_rst)
        powerdown_request_pin [*2] |=> pd_sync_r)
        else $error("power-down pin not followed within two cycles");

    a_pll_a_off: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> pll_a.off == $past(image_w[PD_A_BIT] && pd_sync_r))
        else $error("pll a off does not follow its enable bit");

    a_pll_bc_off: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> pll_b.off == $past(image_w[PD_B_BIT] && pd_sync_r)
            && pll_c.off == $past(image_w[PD_C_BIT] && pd_sync_r))
        else $error("pll b or c off does not follow its enable bit");

    a_post_bc_off: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> post_b.off == $past(image_w[PDPOST_LSB + 1] && pd_sync_r)
            && post_c.off == $past(image_w[PDPOST_LSB + 2] && pd_sync_r))
        else $error("post divider b or c off does not follow its enable bit");

    a_ref_a_field: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> pll_a.ref_div == $past(image_w[REF_A_LSB +: REF_W]))
        else $error("reference divider a taken from wrong field");

    a_fb_a_split: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> pll_a.fb_a == $past(image_w[FB_A_LSB +: FB_A_W])
            && pll_a.fb_m == $past(image_w[FB_A_LSB + FB_A_W +: FB_M_W]))
        else $error("feedback divider a split into wrong counters");

    a_fb_c_set0: assert property (@(posedge clk) disable iff (sys_rst)
        !sel_sync_r |=> pll_c.fb_a == $past(image_w[FB_C0_LSB +: FB_A_W])
            && pll_c.fb_m == $past(image_w[FB_C0_LSB + FB_A_W +: FB_M_W]))
        else $error("feedback divider c not from first set");

    a_fb_c_set1: assert property (@(posedge clk) disable iff (sys_rst)
        sel_sync_r |=> pll_c.fb_a == $past(image_w[FB_C1_LSB +: FB_A_W])
            && pll_c.fb_m == $past(image_w[FB_C1_LSB + FB_A_W +: FB_M_W]))
        else $error("feedback divider c not from second set");

    a_post_a_code: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> post_a.code == $past(image_w[POST_A_LSB +: CODE_W]))
        else $error("post divider a code taken from wrong field");

    a_post_c_set0: assert property (@(posedge clk) disable iff (sys_rst)
        !sel_sync_r |=> post_c.code == $past(image_w[POST_C0_LSB +: CODE_W]))
        else $error("post divider c code not from first set");

    a_post_d_set1: assert property (@(posedge clk) disable iff (sys_rst)
        sel_sync_r |=> post_d.code == $past(image_w[OUT_DIVIDER_CODE_D_SET0_LSB +: CODE_W]))
        else $error("post divider d code not from second set");

    a_ratio_fifteen: assert property (@(posedge clk) disable iff (sys_rst)
        post_b.code == 4'ha |-> post_b.ratio == 6'h0f)
        else $error("code ten does not divide by fifteen");

    a_loop_filter_ab: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> pll_a.loop_long == $past(image_w[LF_A_BIT]) && pll_b.loop_long == $past(image_w[LF_B_BIT]))
        else $error("loop filter of pll a or b not applied");

    a_loop_filter_c0: assert property (@(posedge clk) disable iff (sys_rst)
        !sel_sync_r |=> pll_c.loop_long == $past(image_w[LF_C0_BIT]))
        else $error("loop filter of first c set not applied");

    a_pump_ab: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> pll_a.pump_high == $past(image_w[CP_A_BIT]) && pll_b.pump_high == $past(image_w[CP_B_BIT]))
        else $error("charge pump of pll a or b not applied");

    a_pump_c1: assert property (@(posedge clk) disable iff (sys_rst)
        sel_sync_r |=> pll_c.pump_high == $past(image_w[PUMP_HIGH_CURRENT_C_SET0_BIT]))
        else $error("charge pump of second c set not applied");

    a_write_lands: assert property (@(posedge clk) disable iff (sys_rst)
        reg_req.wr |=> image_w[$past(reg_req.addr) * DATA_W +: DATA_W] == $past(wr_byte))
        else $error("written byte not stored at its write edge");

endmodule

// ### hw/clg_pkg.sv
// shared constants, types and decode function of the clock generator control image
package clg_pkg;

    localparam int IMG_BYTES = 16;
    localparam int IMG_BITS  = IMG_BYTES * 8;
    localparam int ADDR_W    = 4;
    localparam int DATA_W    = 8;

    localparam logic [IMG_BITS-1:0] IMG_RESET = '0;

    // byte lanes holding reserved bits, and the bits that may be stored there
    localparam logic [ADDR_W-1:0] RSVD_BYTE_LF   = 4'hb;
    localparam logic [DATA_W-1:0] RSVD_MASK_LF   = 8'hdf;
    localparam logic [ADDR_W-1:0] RSVD_BYTE_PD   = 4'hf;
    localparam logic [DATA_W-1:0] RSVD_MASK_PD   = 8'h0f;

    // pll field positions
    localparam int REF_A_LSB  = 0;
    localparam int FB_A_LSB   = 8;
    localparam int CP_A_BIT   = 19;
    localparam int LF_A_BIT   = 20;
    localparam int PD_A_BIT   = 21;
    localparam int REF_B_LSB  = 24;
    localparam int FB_B_LSB   = 32;
    localparam int CP_B_BIT   = 43;
    localparam int LF_B_BIT   = 44;
    localparam int PD_B_BIT   = 45;
    localparam int REF_C0_LSB = 48;
    localparam int FB_C0_LSB  = 56;
    localparam int CP_C0_BIT  = 67;
    localparam int LF_C0_BIT  = 68;
    localparam int PD_C_BIT   = 69;
    localparam int REF_C1_LSB = 72;
    localparam int FB_C1_LSB  = 80;
    localparam int PUMP_HIGH_CURRENT_C_SET0_BIT  = 91;
    localparam int LF_C1_BIT  = 92;

    localparam int REF_W      = 8;
    localparam int FB_A_W     = 3;
    localparam int FB_M_W     = 8;

    // post divider field positions
    localparam int POST_A_LSB  = 96;
    localparam int POST_B_LSB  = 100;
    localparam int POST_C0_LSB = 104;
    localparam int POST_D0_LSB = 108;
    localparam int OUT_DIVIDER_CODE_C_SET0_LSB = 112;
    localparam int OUT_DIVIDER_CODE_D_SET0_LSB = 116;
    localparam int PDPOST_LSB  = 120;
    localparam int CODE_W      = 4;
    localparam int RATIO_W     = 6;

    // loop filter time constants, analog: no cycle count is consumed by logic
    localparam int LF_SHORT_NS = 7000;
    localparam int LF_LONG_NS  = 20000;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } clg_bus_t;

    typedef struct packed {
        logic              off;
        logic              loop_long;
        logic              pump_high;
        logic [REF_W-1:0]  ref_div;
        logic [FB_M_W-1:0] fb_m;
        logic [FB_A_W-1:0] fb_a;
    } clg_pll_t;

    typedef struct packed {
        logic               off;
        logic [CODE_W-1:0]  code;
        logic [RATIO_W-1:0] ratio;
    } clg_post_t;

    function automatic logic [RATIO_W-1:0] clg_ratio(input logic [CODE_W-1:0] code);
        logic [RATIO_W-1:0] r;
        r = 6'h01;
        unique case (code)
            4'h0: r = 6'h01;
            4'h1: r = 6'h02;
            4'h2: r = 6'h03;
            4'h3: r = 6'h04;
            4'h4: r = 6'h05;
            4'h5: r = 6'h06;
            4'h6: r = 6'h08;
            4'h7: r = 6'h09;
            4'h8: r = 6'h0a;
            4'h9: r = 6'h0c;
            4'ha: r = 6'h0f;
            4'hb: r = 6'h10;
            4'hc: r = 6'h12;
            4'hd: r = 6'h14;
            4'he: r = 6'h19;
            4'hf: r = 6'h32;
        endcase
        return r;
    endfunction

endpackage

// ### hw/clg_image_mem.sv
// byte-wide control image store with registered read port and flat image view
`timescale 1ns/1ps
module clg_image_mem
    import clg_pkg::*;
#(
    parameter int BYTES = IMG_BYTES
) (
    input  wire logic                      clk,      // system clock
    input  wire logic                      sys_rst,  // synchronous reset
    input  wire logic                      wr_en,    // write strobe
    input  wire logic [ADDR_W-1:0]         wr_addr,  // write byte address
    input  wire logic [DATA_W-1:0]         wr_data,  // write byte
    input  wire logic                      rd_en,    // read strobe
    input  wire logic [ADDR_W-1:0]         rd_addr,  // read byte address
    output logic      [DATA_W-1:0]         rd_data,  // read byte, one cycle later
    output logic      [BYTES*DATA_W-1:0]   image     // whole image
);

    logic [DATA_W-1:0] mem_r [BYTES];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < BYTES; i++) begin
                mem_r[i] <= IMG_RESET[i*DATA_W +: DATA_W];
            end
        end else if (wr_en) begin
            mem_r[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_data <= '0;
        end else if (rd_en) begin
            rd_data <= mem_r[rd_addr];
        end
    end

    always_comb begin
        for (int i = 0; i < BYTES; i++) begin
            image[i*DATA_W +: DATA_W] = mem_r[i];
        end
    end

endmodule

// ### hw/clg_postdiv.sv
// one post divider control: gated power-down and modulus decode, registered
`timescale 1ns/1ps
module clg_postdiv
    import clg_pkg::*;
(
    input  wire logic              clk,        // system clock
    input  wire logic              sys_rst,    // synchronous reset
    input  wire logic [CODE_W-1:0] code,       // selected divider code
    input  wire logic              off_enable, // power-down enable bit
    input  wire logic              pd_active,  // synchronised power-down request
    output clg_post_t              post        // registered divider control
);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            post <= '0;
        end else begin
            post.off   <= off_enable & pd_active;
            post.code  <= code;
            post.ratio <= clg_ratio(code);
        end
    end

    a_ratio_decode: assert property (@(posedge clk) disable iff (sys_rst)
        !$past(sys_rst) |-> post.ratio == clg_ratio(post.code))
        else $error("post divider ratio does not match its code");

    a_post_off_gate: assert property (@(posedge clk) disable iff (sys_rst)
        !pd_active ##1 !pd_active |-> !post.off)
        else $error("post divider off while power-down not requested");

endmodule

// ### verif/clg_host_model.sv
// host side model: writes and reads control image bytes over the register port
`timescale 1ns/1ps
module clg_host_model
    import clg_pkg::*;
(
    input  wire logic              clk,       // system clock
    input  wire logic [DATA_W-1:0] reg_rdata, // read byte from the device
    output clg_bus_t               reg_req    // register request to the device
);
    initial begin
        reg_req = '0;
    end

    // reserved positions are always sent as zero
    function automatic logic [DATA_W-1:0] legal(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        if (a == RSVD_BYTE_LF) begin
            return d & RSVD_MASK_LF;
        end
        if (a == RSVD_BYTE_PD) begin
            return d & RSVD_MASK_PD;
        end
        return d;
    endfunction

    task automatic write_byte(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        reg_req.wr    <= 1'b1;
        reg_req.addr  <= a;
        reg_req.wdata <= legal(a, d);
        @(posedge clk);
        reg_req.wr    <= 1'b0;
    endtask

    task automatic read_byte(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        reg_req.rd   <= 1'b1;
        reg_req.addr <= a;
        @(posedge clk);
        reg_req.rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
endmodule

// ### verif/clg_config_bench.sv
// self-checking bench of the control image decode
`timescale 1ns/1ps
module clg_config_bench
    import clg_pkg::*;
;
    logic                clk;
    logic                sys_rst;
    logic                powerdown_request_pin;
    logic                cd_set_select_pin;
    clg_bus_t            reg_req;
    logic [DATA_W-1:0]   reg_rdata;
    clg_pll_t            pll_a;
    clg_pll_t            pll_b;
    clg_pll_t            pll_c;
    clg_post_t           post_a;
    clg_post_t           post_b;
    clg_post_t           post_c;
    clg_post_t           post_d;
    logic                pd_active;
    logic                cd_set1_active;
    logic [IMG_BITS-1:0] img;
    logic [DATA_W-1:0]   rd;
    logic [3:0]          c;
    int                  error_cnt;
    int                  tests_run;

    localparam int RATIO [16] = '{1, 2, 3, 4, 5, 6, 8, 9, 10, 12, 15, 16, 18, 20, 25, 50};

    clg_host_model host_u (
        .clk       (clk),
        .reg_rdata (reg_rdata),
        .reg_req   (reg_req)
    );

    clg_config dut_u (
        .clk                   (clk),
        .sys_rst               (sys_rst),
        .reg_req               (reg_req),
        .reg_rdata             (reg_rdata),
        .powerdown_request_pin (powerdown_request_pin),
        .cd_set_select_pin     (cd_set_select_pin),
        .pll_a                 (pll_a),
        .pll_b                 (pll_b),
        .pll_c                 (pll_c),
        .post_a                (post_a),
        .post_b                (post_b),
        .post_c                (post_c),
        .post_d                (post_d),
        .pd_active             (pd_active),
        .cd_set1_active        (cd_set1_active)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // write through the host and keep the mirror, reserved bits held at zero
    task automatic wb(input logic [3:0] a, input logic [7:0] d);
        host_u.write_byte(a, d);
        img[a*8+:8] = d & ((a == 4'hb) ? 8'hdf : (a == 4'hf) ? 8'h0f : 8'hff);
    endtask

    task automatic settle;
        repeat (4) @(posedge clk);
        #1;
    endtask

    function automatic logic [31:0] exp_pll(input int r, input int f, input int cp, input int lf, input int pdb);
        return 32'({img[pdb] & powerdown_request_pin, img[lf], img[cp], img[r+:8], img[f+3+:8], img[f+:3]});
    endfunction

    function automatic logic [31:0] exp_post(input int lsb, input int pdb);
        logic [3:0] code;
        code = img[lsb+:4];
        return 32'({img[pdb] & powerdown_request_pin, code, 6'(RATIO[code])});
    endfunction

    task automatic check_all;
        logic s;
        s = cd_set_select_pin;
        chk(32'(pll_a), exp_pll(0, 8, 19, 20, 21));
        chk(32'(pll_b), exp_pll(24, 32, 43, 44, 45));
        chk(32'(pll_c), s ? exp_pll(72, 80, 91, 92, 69) : exp_pll(48, 56, 67, 68, 69));
        chk(32'(post_a), exp_post(96, 120));
        chk(32'(post_b), exp_post(100, 121));
        chk(32'(post_c), exp_post(s ? 112 : 104, 122));
        chk(32'(post_d), exp_post(s ? 116 : 108, 123));
        chk(32'(pd_active), 32'(powerdown_request_pin));
        chk(32'(cd_set1_active), 32'(cd_set_select_pin));
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // hang guard
    initial begin
        for (int i = 0; i < 20000; i++) begin
            @(posedge clk);
        end
        error_cnt++;
        report_and_stop();
    end

    initial begin
        sys_rst               = 1'b1;
        powerdown_request_pin = 1'b0;
        cd_set_select_pin     = 1'b0;
        img                   = '0;
        error_cnt             = 0;
        tests_run             = 0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        for (int a = 0; a < 16; a++) begin
            host_u.read_byte(4'(a), rd);
            chk(32'(rd), 32'h0);
        end
        settle();
        check_all();
        // full image pattern, read back
        for (int a = 0; a < 16; a++) begin
            wb(4'(a), 8'(8'h35 + a * 8'h1d));
        end
        for (int a = 0; a < 16; a++) begin
            host_u.read_byte(4'(a), rd);
            chk(32'(rd), 32'(img[a*8+:8]));
        end
        // a single byte shows at the outputs one edge after it is taken
        wb(4'h0, 8'h5a);
        @(posedge clk);
        #1;
        chk(32'(pll_a.ref_div), 32'h5a);
        // every post code, with pins and enables varied
        for (int k = 0; k < 16; k++) begin
            c = 4'(k);
            wb(4'hc, {c, ~c});
            wb(4'hd, {~c, c});
            wb(4'he, {c, c + 4'h3});
            wb(4'hf, {4'hf, c});
            wb(4'h8, {c, ~c});
            wb(4'hb, {c, ~c});
            wb(4'h2, {c, ~c});
            wb(4'h5, {~c, c});
            @(posedge clk);
            cd_set_select_pin     <= c[0];
            powerdown_request_pin <= c[2];
            settle();
            check_all();
        end
        // switching the select alone swaps the c/d set
        @(posedge clk);
        cd_set_select_pin <= ~cd_set_select_pin;
        settle();
        check_all();
        report_and_stop();
    end
endmodule
